// [inc/tde_pkg.sv]
// Shared constants and types of the test access port controller.
package tde_pkg;

    // Controller states, Gray coded along the usual path.
    typedef enum logic [3:0] {
        TDE_RESET    = 4'h0,
        TDE_IDLE     = 4'h1,
        TDE_SEL_DR   = 4'h3,
        TDE_CAP_DR   = 4'h2,
        TDE_SHIFT_DR = 4'h6,
        TDE_EXIT1_DR = 4'h7,
        TDE_PAUSE_DR = 4'h5,
        TDE_EXIT2_DR = 4'h4,
        TDE_UPD_DR   = 4'hc,
        TDE_SEL_IR   = 4'hd,
        TDE_CAP_IR   = 4'hf,
        TDE_SHIFT_IR = 4'he,
        TDE_EXIT1_IR = 4'ha,
        TDE_PAUSE_IR = 4'hb,
        TDE_EXIT2_IR = 4'h9,
        TDE_UPD_IR   = 4'h8
    } tde_state_e;

    localparam int TDE_IR_W = 3;
    localparam int TDE_ID_W = 32;
    localparam int TDE_RESET_HIGHS = 5;

    // Fixed pattern loaded into the instruction shift stage on capture.
    localparam logic [TDE_IR_W-1:0] TDE_IR_CAPTURE = 3'h4;

    // Instruction codes; the values are arbitrary.
    localparam logic [TDE_IR_W-1:0] TDE_INS_EXTEST = 3'h0;
    localparam logic [TDE_IR_W-1:0] TDE_INS_SAMPLE = 3'h1;
    localparam logic [TDE_IR_W-1:0] TDE_INS_IDCODE = 3'h2;
    localparam logic [TDE_IR_W-1:0] TDE_INS_BYPASS = 3'h7;

    // Identification value; the value is arbitrary.
    localparam logic [TDE_ID_W-1:0] TDE_ID_VALUE = 32'h0000_1001;

    // Functional-mode synchroniser after reset: both stages show normal use.
    localparam logic [1:0] TDE_SYNC_RESET = 2'h3;

endpackage : tde_pkg

// [rtl/tde_tap.sv]
// Test access port controller with its data and instruction registers.
`timescale 1ns/1ns
module tde_tap #(
    parameter int BSR_W = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic [BSR_W-1:0] pins,
    output logic tdo,
    output logic tdo_oe,
    output logic [BSR_W-1:0] bs_out,
    output logic test_active,
    output logic func_mode
);

    localparam int DR_W = (BSR_W > tde_pkg::TDE_ID_W) ?
        BSR_W : tde_pkg::TDE_ID_W;

    if (BSR_W < 2) begin : g_bad_width
        $error("Boundary register must have at least two stages.");
    end

    ////////////////////////////////////////////////////////////////////////
    // Test clock domain state.

    typedef struct packed {
        logic [1:0] ce_sync;
        logic [BSR_W-1:0] pin_s1;
        logic [BSR_W-1:0] pin_s2;
        tde_pkg::tde_state_e state;
        logic [tde_pkg::TDE_IR_W-1:0] ir;
        logic [tde_pkg::TDE_IR_W-1:0] ir_sh;
        logic [DR_W-1:0] dr;
        logic [BSR_W-1:0] bs_out;
        logic tdo;
        logic tdo_oe;
        logic active;
    } tde_tck_s;

    tde_tck_s t;
    tde_tck_s next_t;

    logic ce_t;
    logic sel_bsr;
    logic sel_id;
    int dr_len;

    assign ce_t = t.ce_sync[1];
    assign sel_bsr = (t.ir == tde_pkg::TDE_INS_EXTEST) ||
                     (t.ir == tde_pkg::TDE_INS_SAMPLE);
    assign sel_id = (t.ir == tde_pkg::TDE_INS_IDCODE);

    always_comb begin
        next_t = t;
        next_t.ce_sync = {t.ce_sync[0], ce};
        next_t.pin_s1 = pins;
        next_t.pin_s2 = t.pin_s1;
        dr_len = sel_bsr ? BSR_W : (sel_id ? tde_pkg::TDE_ID_W : 1);
        if (ce_t) begin
            case (t.state)
                tde_pkg::TDE_RESET: begin
                    next_t.state = tms ? tde_pkg::TDE_RESET
                                       : tde_pkg::TDE_IDLE;
                end
                tde_pkg::TDE_IDLE: begin
                    next_t.state = tms ? tde_pkg::TDE_SEL_DR
                                       : tde_pkg::TDE_IDLE;
                end
                tde_pkg::TDE_SEL_DR: begin
                    next_t.state = tms ? tde_pkg::TDE_SEL_IR
                                       : tde_pkg::TDE_CAP_DR;
                end
                tde_pkg::TDE_CAP_DR: begin
                    if (sel_bsr) begin
                        next_t.dr[BSR_W-1:0] = t.pin_s2;
                    end else if (sel_id) begin
                        next_t.dr[tde_pkg::TDE_ID_W-1:0] =
                            tde_pkg::TDE_ID_VALUE;
                    end
                    next_t.state = tms ? tde_pkg::TDE_EXIT1_DR
                                       : tde_pkg::TDE_SHIFT_DR;
                end
                tde_pkg::TDE_SHIFT_DR: begin
                    for (int i = 0; i < DR_W; i++) begin
                        if (i == dr_len - 1) begin
                            next_t.dr[i] = tdi;
                        end else if (i < dr_len - 1) begin
                            next_t.dr[i] = t.dr[i+1];
                        end
                    end
                    next_t.state = tms ? tde_pkg::TDE_EXIT1_DR
                                       : tde_pkg::TDE_SHIFT_DR;
                end
                tde_pkg::TDE_EXIT1_DR: begin
                    next_t.state = tms ? tde_pkg::TDE_UPD_DR
                                       : tde_pkg::TDE_PAUSE_DR;
                end
                tde_pkg::TDE_PAUSE_DR: begin
                    next_t.state = tms ? tde_pkg::TDE_EXIT2_DR
                                       : tde_pkg::TDE_PAUSE_DR;
                end
                tde_pkg::TDE_EXIT2_DR: begin
                    next_t.state = tms ? tde_pkg::TDE_UPD_DR
                                       : tde_pkg::TDE_SHIFT_DR;
                end
                tde_pkg::TDE_UPD_DR: begin
                    if (sel_bsr) begin
                        next_t.bs_out = t.dr[BSR_W-1:0];
                    end
                    next_t.state = tms ? tde_pkg::TDE_SEL_DR
                                       : tde_pkg::TDE_IDLE;
                end
                tde_pkg::TDE_SEL_IR: begin
                    next_t.state = tms ? tde_pkg::TDE_RESET
                                       : tde_pkg::TDE_CAP_IR;
                end
                tde_pkg::TDE_CAP_IR: begin
                    next_t.ir_sh = tde_pkg::TDE_IR_CAPTURE;
                    next_t.state = tms ? tde_pkg::TDE_EXIT1_IR
                                       : tde_pkg::TDE_SHIFT_IR;
                end
                tde_pkg::TDE_SHIFT_IR: begin
                    next_t.ir_sh = {tdi, t.ir_sh[tde_pkg::TDE_IR_W-1:1]};
                    next_t.state = tms ? tde_pkg::TDE_EXIT1_IR
                                       : tde_pkg::TDE_SHIFT_IR;
                end
                tde_pkg::TDE_EXIT1_IR: begin
                    next_t.state = tms ? tde_pkg::TDE_UPD_IR
                                       : tde_pkg::TDE_PAUSE_IR;
                end
                tde_pkg::TDE_PAUSE_IR: begin
                    next_t.state = tms ? tde_pkg::TDE_EXIT2_IR
                                       : tde_pkg::TDE_PAUSE_IR;
                end
                tde_pkg::TDE_EXIT2_IR: begin
                    next_t.state = tms ? tde_pkg::TDE_UPD_IR
                                       : tde_pkg::TDE_SHIFT_IR;
                end
                tde_pkg::TDE_UPD_IR: begin
                    next_t.ir = t.ir_sh;
                    next_t.state = tms ? tde_pkg::TDE_SEL_DR
                                       : tde_pkg::TDE_IDLE;
                end
                default: begin
                    next_t.state = tde_pkg::TDE_RESET;
                end
            endcase
            // The reset state is reached by five highs from anywhere.
            if (next_t.state == tde_pkg::TDE_RESET) begin
                next_t.ir = tde_pkg::TDE_INS_IDCODE;
            end
            next_t.active = (next_t.state != tde_pkg::TDE_RESET);
            next_t.tdo_oe = (next_t.state == tde_pkg::TDE_SHIFT_DR) ||
                            (next_t.state == tde_pkg::TDE_SHIFT_IR);
            if (next_t.state == tde_pkg::TDE_SHIFT_DR) begin
                next_t.tdo = next_t.dr[0];
            end else if (next_t.state == tde_pkg::TDE_SHIFT_IR) begin
                next_t.tdo = next_t.ir_sh[0];
            end else begin
                next_t.tdo = 1'b0;
            end
        end
    end

    always_ff @(posedge tck or negedge rst_n) begin
        if (!rst_n) begin
            t <= '0;
            t.state <= tde_pkg::TDE_RESET;
            t.ir <= tde_pkg::TDE_INS_IDCODE;
        end else begin
            t <= next_t;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // System clock domain: the inverse of the test-active flop crosses by
    // two flops, so the functional-mode output comes straight from a flop.

    typedef struct packed {
        logic [1:0] func_sync;
    } tde_m_s;

    tde_m_s m;
    tde_m_s next_m;

    always_comb begin
        next_m = m;
        if (ce) begin
            next_m.func_sync = {m.func_sync[0], !t.active};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            m.func_sync <= tde_pkg::TDE_SYNC_RESET;
        end else begin
            m <= next_m;
        end
    end

    assign tdo = t.tdo;
    assign tdo_oe = t.tdo_oe;
    assign bs_out = t.bs_out;
    assign test_active = t.active;
    assign func_mode = m.func_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    chk_reset_five: assert property (
        @(posedge tck) disable iff (!rst_n)
        (ce_t && tms) [*5] |=> t.state == tde_pkg::TDE_RESET)
        else $error("Five high mode-select samples did not reset.");

    chk_reset_hold: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_RESET && tms && ce_t
        |=> t.state == tde_pkg::TDE_RESET)
        else $error("Reset state left while mode-select high.");

    chk_reset_idcode: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_RESET |-> t.ir == tde_pkg::TDE_INS_IDCODE)
        else $error("Instruction not identification in reset state.");

    chk_reset_quiet: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_RESET |-> !t.active && !t.tdo_oe)
        else $error("Test logic active in reset state.");

    chk_idle_stay: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_IDLE && ce_t |=> t.state ==
        ($past(tms) ? tde_pkg::TDE_SEL_DR : tde_pkg::TDE_IDLE))
        else $error("Wrong step out of idle.");

    chk_idle_hold: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_IDLE && !tms && ce_t
        |=> $stable(t.ir) && $stable(t.dr))
        else $error("Registers changed while idle.");

    chk_sel_dr_step: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_SEL_DR && ce_t |=> $stable(t.ir) &&
        t.state == ($past(tms) ? tde_pkg::TDE_SEL_IR : tde_pkg::TDE_CAP_DR))
        else $error("Wrong step out of data select.");

    chk_capture_pins: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_CAP_DR && ce_t && sel_bsr
        |=> t.dr[BSR_W-1:0] == $past(t.pin_s2))
        else $error("Boundary register did not capture pins.");

    chk_capture_step: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_CAP_DR && ce_t |=> t.state ==
        ($past(tms) ? tde_pkg::TDE_EXIT1_DR : tde_pkg::TDE_SHIFT_DR))
        else $error("Wrong step out of capture.");

    chk_shift_stage: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_SHIFT_DR && ce_t && sel_bsr
        |=> t.dr[0] == $past(t.dr[1]) && t.dr[BSR_W-1] == $past(tdi))
        else $error("Boundary register did not shift one stage.");

    chk_shift_step: assert property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_SHIFT_DR && ce_t |=> t.state ==
        ($past(tms) ? tde_pkg::TDE_EXIT1_DR : tde_pkg::TDE_SHIFT_DR))
        else $error("Wrong step out of shift.");

    cov_shift_dr: cover property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_SHIFT_DR && sel_bsr);

    cov_update_ir: cover property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_UPD_IR);

    cov_forced_reset: cover property (
        @(posedge tck) disable iff (!rst_n)
        t.state == tde_pkg::TDE_SHIFT_DR ##1
        (ce_t && tms) [*5] ##1 t.state == tde_pkg::TDE_RESET);

endmodule : tde_tap

// [dv/tde_host.sv]
// Board test controller model driving the scan clock and mode lines.
`timescale 1ns/1ns
module tde_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Between frames the clock stands low and the pulled-up lines read high.
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One clock cycle; both lines change only while the clock is low.
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #8 tck = 1'b1;
        #7 tck = 1'b0;
    endtask : step

    // Shifts n bits LSB first, reading the output before each edge.
    task automatic scan(input int n, input logic [31:0] din,
                        output logic [31:0] dout);
        dout = '0;
        for (int i = 0; i < n; i++) begin
            // A released data-out line reads as its pull-up.
            dout[i] = tdo_oe ? tdo : 1'b1;
            step(i == n - 1, din[i]);
        end
    endtask : scan

    // Idles the lines for one period so a following frame starts later.
    task automatic rest();
        tms = 1'b1;
        tdi = 1'b1;
        #15;
    endtask : rest
endmodule : tde_host

// [dv/tde_tap_tb_top.sv]
// Self-checking bench for the test access port controller.
`timescale 1ns/1ns
module tde_tap_tb_top;
    localparam int BSR_W = 8;
    logic mclk;
    logic rst_n;
    logic ce;
    logic tck, tms, tdi, tdo, tdo_oe, test_active, func_mode;
    logic [BSR_W-1:0] pins;
    logic [BSR_W-1:0] bs_out;
    logic [31:0] got;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    tde_tap #(.BSR_W(BSR_W)) DUT (.mclk(mclk), .rst_n(rst_n), .ce(ce),
        .tck(tck), .tms(tms), .tdi(tdi), .pins(pins), .tdo(tdo),
        .tdo_oe(tdo_oe), .bs_out(bs_out), .test_active(test_active),
        .func_mode(func_mode));

    tde_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s seen %h wanted %h", $time,
                     what, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic highs(input int n);
        repeat (n) host.step(1'b1, 1'b1);
    endtask : highs

    task automatic mwait();
        repeat (4) @(negedge mclk);
    endtask : mwait

    // From reset or idle, walks to the data shift state.
    task automatic to_shift();
        host.step(1'b0, 1'b0);
        host.step(1'b1, 1'b0);
        host.step(1'b0, 1'b0);
        host.step(1'b0, 1'b0);
    endtask : to_shift

    task automatic t_power_up();
        check(test_active, 1'b0, "active after reset");
        check(func_mode, 1'b1, "functional after reset");
        highs(4);
        check(test_active, 1'b0, "reset held");
        check(tdo_oe, 1'b0, "no drive in reset");
        $display("test power_up done");
    endtask : t_power_up

    task automatic t_idcode();
        host.step(1'b0, 1'b0);
        host.step(1'b0, 1'b0);
        check(test_active, 1'b1, "idle entered");
        mwait();
        check(func_mode, 1'b0, "test mode");
        host.step(1'b1, 1'b0);
        check(tdo_oe, 1'b0, "data select");
        host.step(1'b0, 1'b0);
        host.step(1'b0, 1'b0);
        check(tdo_oe, 1'b1, "shift entered");
        host.scan(32, 32'h0, got);
        check(got, tde_pkg::TDE_ID_VALUE, "identification");
        check(tdo_oe, 1'b0, "shift left");
        highs(5);
        check(test_active, 1'b0, "back to reset");
        mwait();
        check(func_mode, 1'b1, "functional again");
        host.rest();
        $display("test idcode done");
    endtask : t_idcode

    task automatic t_branches();
        host.step(1'b0, 1'b0);
        host.step(1'b1, 1'b0);
        host.step(1'b0, 1'b0);
        host.step(1'b1, 1'b0);
        check(tdo_oe, 1'b0, "capture to exit");
        host.step(1'b1, 1'b0);
        host.step(1'b0, 1'b0);
        host.step(1'b1, 1'b0);
        host.step(1'b1, 1'b0);
        check(test_active, 1'b1, "instruction select");
        host.step(1'b1, 1'b0);
        check(test_active, 1'b0, "select to reset");
        to_shift();
        highs(4);
        check(test_active, 1'b1, "four highs");
        highs(1);
        check(test_active, 1'b0, "five highs");
        host.rest();
        $display("test branches done");
    endtask : t_branches

    // Clock enable low freezes the controller after its two sync stages.
    task automatic t_freeze();
        @(negedge mclk);
        ce = 1'b0;
        highs(2);
        repeat (3) host.step(1'b0, 1'b0);
        check(test_active, 1'b0, "frozen in reset");
        @(negedge mclk);
        ce = 1'b1;
        highs(2);
        host.step(1'b0, 1'b0);
        check(test_active, 1'b1, "running again");
        highs(5);
        host.rest();
        $display("test freeze done");
    endtask : t_freeze

    task automatic t_boundary();
        @(negedge mclk);
        pins = 8'ha5;
        host.step(1'b0, 1'b0);
        highs(2);
        host.step(1'b0, 1'b0);
        host.step(1'b0, 1'b0);
        host.scan(3, {29'h0, tde_pkg::TDE_INS_SAMPLE}, got);
        host.step(1'b1, 1'b0);
        repeat (3) host.step(1'b0, 1'b0);
        check(bs_out, 8'h00, "idle keeps output");
        to_shift();
        host.scan(8, 32'h3c, got);
        check(got[7:0], 8'ha5, "pins captured");
        check(bs_out, 8'h00, "output held in exit");
        host.step(1'b1, 1'b0);
        host.step(1'b0, 1'b0);
        check(bs_out, 8'h3c, "output updated");
        @(negedge mclk);
        pins = 8'h5a;
        repeat (3) host.step(1'b0, 1'b0);
        check(bs_out, 8'h3c, "idle keeps update");
        to_shift();
        host.scan(8, 32'h0, got);
        check(got[7:0], 8'h5a, "instruction kept");
        highs(5);
        host.rest();
        $display("test boundary done");
    endtask : t_boundary

    initial begin
        rst_n = 1'b0;
        ce = 1'b0;
        pins = '0;
        @(negedge mclk);
        host.step(1'b1, 1'b1);
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        ce = 1'b1;
        t_power_up();
        t_idcode();
        t_branches();
        t_freeze();
        t_boundary();
        t_idcode();
        end_sim();
    end
endmodule : tde_tap_tb_top
